/* design/srw_pkg.sv */
// constants, types and helpers shared by the readout window register bank
package srw_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CHIP_ID = 8'h00;
	localparam logic [7:0] OFS_FIRST_ROW = 8'h01;
	localparam logic [7:0] OFS_FIRST_COL = 8'h02;
	localparam logic [7:0] OFS_ROW_COUNT = 8'h03;
	localparam logic [7:0] OFS_COL_COUNT = 8'h04;
	localparam logic [7:0] OFS_HBLANK_B = 8'h05;
	localparam int NUM_RW = 5;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int WIN_W = 11;
	localparam int HBLANK_W = 14;
	localparam logic [15:0] MASK_WIN = 16'h07FF;
	localparam logic [15:0] MASK_HBLANK = 16'h3FFF;
	localparam logic [15:0] RST_FIRST_ROW = 16'h001C;
	localparam logic [15:0] RST_FIRST_COL = 16'h003C;
	localparam logic [15:0] RST_ROW_COUNT = 16'h04B0;
	localparam logic [15:0] RST_COL_COUNT = 16'h0640;
	localparam logic [15:0] RST_HBLANK_B = 16'h015C;
	// blanking used while context A is selected
	localparam logic [13:0] HBLANK_A = 14'h00AE;

	typedef logic [NUM_RW:1][15:0] srw_bank_type;
	localparam srw_bank_type RST_BANK = {RST_HBLANK_B, RST_COL_COUNT, RST_ROW_COUNT, RST_FIRST_COL, RST_FIRST_ROW};

	// ----------------------------------------------------------------
	// frame timing
	// ----------------------------------------------------------------
	// dark rows read before the image, i.e. frame start lead in rows
	localparam logic [15:0] DARK_ROWS = 16'h0008;
	localparam logic [15:0] VBLANK_ROWS = 16'h0020;

	// ----------------------------------------------------------------
	// serial port
	// ----------------------------------------------------------------
	// arbitrary default address and identification values
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h3C;
	localparam logic [15:0] CHIP_ID_DEFAULT = 16'hA5C3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_DEV = 9'h002,
		ST_ACK_DEV = 9'h004,
		ST_REG = 9'h008,
		ST_ACK_REG = 9'h010,
		ST_WDATA = 9'h020,
		ST_ACK_WR = 9'h040,
		ST_RDATA = 9'h080,
		ST_ACK_RD = 9'h100
	} srw_state_type;

	function automatic logic [15:0] srw_field_mask(input logic [7:0] ofs);
		case (ofs)
			OFS_FIRST_ROW, OFS_FIRST_COL, OFS_ROW_COUNT, OFS_COL_COUNT: srw_field_mask = MASK_WIN;
			OFS_HBLANK_B: srw_field_mask = MASK_HBLANK;
			default: srw_field_mask = 16'h0000;
		endcase
	endfunction

endpackage

/* design/srw_cfg_if.sv */
// applied readout settings and timing strobes between bank and timing generator
`timescale 1ns/1ps
interface srw_cfg_if;
	logic [10:0] first_row;
	logic [10:0] first_col;
	logic [10:0] row_count;
	logic [10:0] col_count;
	logic [13:0] hblank;
	logic frame_start;
	logic fv;
	logic lv;
	logic [10:0] row_addr;
	logic [10:0] col_addr;

	modport bank (output first_row, first_col, row_count, col_count, hblank,
		input frame_start, fv, lv, row_addr, col_addr);
	modport timing (input first_row, first_col, row_count, col_count, hblank,
		output frame_start, fv, lv, row_addr, col_addr);
endinterface

/* design/srw_readout_timing.sv */
// row and column counters that pace the readout and mark frame start
`timescale 1ns/1ps
module srw_readout_timing (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	srw_cfg_if.timing cfg
);
	logic [15:0] col_r, col_nxt, row_r, row_nxt;
	logic fs_r, fs_nxt, fv_r, fv_nxt, lv_r, lv_nxt;
	logic [10:0] ra_r, ra_nxt, ca_r, ca_nxt;
	logic [15:0] line_len, frame_len, img_end, row_ofs, col_ofs;

	always_comb begin
		// blanking columns come first in every row
		line_len = {2'b00, cfg.hblank} + {5'b00000, cfg.col_count}; // RL14
		img_end = srw_pkg::DARK_ROWS + {5'b00000, cfg.row_count};
		frame_len = img_end + srw_pkg::VBLANK_ROWS;
		col_nxt = col_r + 16'h0001;
		row_nxt = row_r;
		// >= keeps the counters bounded if a length shrinks
		if (col_nxt >= line_len) begin
			col_nxt = 16'h0000;
			row_nxt = row_r + 16'h0001;
			if (row_nxt >= frame_len)
				row_nxt = 16'h0000;
		end
		// first dark row, first column
		fs_nxt = (row_nxt == 16'h0000) && (col_nxt == 16'h0000); // RL3
		fv_nxt = (row_nxt >= srw_pkg::DARK_ROWS) && (row_nxt < img_end); // RL4
		lv_nxt = fv_nxt && (col_nxt >= {2'b00, cfg.hblank}); // RL14
		row_ofs = row_nxt - srw_pkg::DARK_ROWS;
		col_ofs = col_nxt - {2'b00, cfg.hblank};
		ra_nxt = fv_nxt ? cfg.first_row + row_ofs[10:0] : ra_r; // RL7
		ca_nxt = lv_nxt ? cfg.first_col + col_ofs[10:0] : ca_r; // RL9
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			col_r <= 16'h0000;
			row_r <= 16'h0000;
			fs_r <= 1'b0;
			fv_r <= 1'b0;
			lv_r <= 1'b0;
			ra_r <= 11'h000;
			ca_r <= 11'h000;
		end else if (ce_i) begin
			col_r <= col_nxt;
			row_r <= row_nxt;
			fs_r <= fs_nxt;
			fv_r <= fv_nxt;
			lv_r <= lv_nxt;
			ra_r <= ra_nxt;
			ca_r <= ca_nxt;
		end
	end

	assign cfg.frame_start = fs_r;
	assign cfg.fv = fv_r;
	assign cfg.lv = lv_r;
	assign cfg.row_addr = ra_r;
	assign cfg.col_addr = ca_r;

	a_fv_lead_rows: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RL4
		$rose(fv_r) |-> (row_r == srw_pkg::DARK_ROWS) && (col_r == 16'h0000))
		else $error("frame active did not rise at the end of the dark rows");
	// line active was decided with last cycle's blanking, which may switch mid row
	a_blank_first: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RL14
		lv_r && $past(ce_i) |-> (col_r >= {2'b00, $past(cfg.hblank)}))
		else $error("line active inside horizontal blanking");
endmodule

/* design/srw_readout_regs.sv */
// readout window register bank with two-wire serial slave and frame-synced apply
`timescale 1ns/1ps
// How it works
// RL1 - unsynced settings like context select take effect immediately.
// RL2 - synced writes wait pending, applied at next frame start if sync bit clear.
// RL3 - frame start is the cycle the first dark row begins.
// RL4 - frame start leads frame active by eight dark rows.
// RL5 - integration or offset change within a frame marks it bad.
// RL6 - bad frame from masked-bad write is hidden unless show-bad is set.
// RL7 - first row, 11 bits, reset 1C, synced, masked bad frame.
// RL8 - host keeps first row at 20 or more.
// RL9 - first column, 11 bits, reset 3C, synced, masked bad frame.
// RL10 - host keeps first column at 52 or more.
// RL11 - row count, reset 4B0, host keeps it at 2 or more.
// RL12 - column count, reset 640, minimum 9 or 17 by converter mode.
// RL13 - context B blanking, 14 bits, reset 15C, used only when context is B.
// RL14 - blanking columns precede active columns in every row.
// RL15 - register zero reads a fixed identification, ignores writes.
// RL16 - while sync bit set, pending values hold and apply together afterwards.
module srw_readout_regs #(
	parameter logic [6:0] SLAVE_ADDR = srw_pkg::SLAVE_ADDR_DEFAULT,
	parameter logic [15:0] CHIP_ID = srw_pkg::CHIP_ID_DEFAULT
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic sync_changes_i,
	input wire logic context_select_i,
	input wire logic show_bad_frames_i,
	input wire logic integ_change_i,
	input wire logic offset_change_i,
	output logic frame_start_o,
	output logic frame_valid_o,
	output logic line_valid_o,
	output logic [10:0] row_addr_o,
	output logic [10:0] col_addr_o,
	output logic bad_frame_o
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	logic rise, fall, start_ev, stop_ev;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
		end else if (ce_i) begin
			{scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
		end
	end

	assign rise = scl_s_r && !scl_d_r;
	assign fall = !scl_s_r && scl_d_r;
	assign start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
	assign stop_ev = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	srw_pkg::srw_bank_type pend_r, pend_nxt, act_r, act_nxt;
	logic dirty_r, dirty_nxt, wr_en;
	logic [15:0] wr_data;
	logic [7:0] ptr_r, ptr_nxt;

	function automatic logic [15:0] rd_val(input logic [7:0] ofs, input srw_pkg::srw_bank_type bank);
		if (ofs == srw_pkg::OFS_CHIP_ID)
			rd_val = CHIP_ID; // RL15
		else if (srw_pkg::srw_field_mask(ofs) != 16'h0000)
			rd_val = bank[ofs[2:0]];
		else
			rd_val = 16'h0000;
	endfunction

	// ----------------------------------------------------------------
	// serial slave
	// ----------------------------------------------------------------
	srw_pkg::srw_state_type st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, hold_r, hold_nxt;
	logic hi_r, hi_nxt, oe_r, oe_nxt;
	logic [15:0] rd_cur, rd_next;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		hold_nxt = hold_r;
		hi_nxt = hi_r;
		oe_nxt = oe_r;
		wr_en = 1'b0;
		wr_data = 16'h0000;
		rd_cur = rd_val(ptr_r, pend_r);
		rd_next = rd_val(ptr_r + 8'h01, pend_r);
		if (start_ev) begin
			st_nxt = srw_pkg::ST_DEV;
			cnt_nxt = 4'h0;
			oe_nxt = 1'b0;
		end else if (stop_ev) begin
			st_nxt = srw_pkg::ST_IDLE;
			oe_nxt = 1'b0;
		end else if (rise) begin
			case (st_r)
				srw_pkg::ST_DEV, srw_pkg::ST_REG, srw_pkg::ST_WDATA, srw_pkg::ST_RDATA: begin
					sh_nxt = {sh_r[6:0], sda_s_r};
					cnt_nxt = cnt_r + 4'h1;
				end
				// master nack ends the read
				srw_pkg::ST_ACK_RD: if (sda_s_r) st_nxt = srw_pkg::ST_IDLE;
				default: ;
			endcase
		end else if (fall) begin
			case (st_r)
				srw_pkg::ST_DEV: if (cnt_r == srw_pkg::BITS_PER_BYTE) begin
					cnt_nxt = 4'h0;
					if (sh_r[7:1] == SLAVE_ADDR) begin
						oe_nxt = 1'b1;
						st_nxt = srw_pkg::ST_ACK_DEV;
					end else begin
						st_nxt = srw_pkg::ST_IDLE;
					end
				end
				srw_pkg::ST_ACK_DEV: begin
					// sh_r still holds the address byte, bit 0 is read/write
					if (sh_r[0]) begin
						tx_nxt = rd_cur[15:8];
						oe_nxt = !rd_cur[15];
						hi_nxt = 1'b0;
						st_nxt = srw_pkg::ST_RDATA;
					end else begin
						oe_nxt = 1'b0;
						st_nxt = srw_pkg::ST_REG;
					end
				end
				srw_pkg::ST_REG: if (cnt_r == srw_pkg::BITS_PER_BYTE) begin
					ptr_nxt = sh_r;
					cnt_nxt = 4'h0;
					oe_nxt = 1'b1;
					st_nxt = srw_pkg::ST_ACK_REG;
				end
				srw_pkg::ST_ACK_REG, srw_pkg::ST_ACK_WR: begin
					oe_nxt = 1'b0;
					if (st_r == srw_pkg::ST_ACK_REG)
						hi_nxt = 1'b1;
					st_nxt = srw_pkg::ST_WDATA;
				end
				srw_pkg::ST_WDATA: if (cnt_r == srw_pkg::BITS_PER_BYTE) begin
					// high byte first, the word lands with its low byte
					if (hi_r) begin
						hold_nxt = sh_r;
						hi_nxt = 1'b0;
					end else begin
						wr_en = 1'b1;
						wr_data = {hold_r, sh_r};
						ptr_nxt = ptr_r + 8'h01;
						hi_nxt = 1'b1;
					end
					cnt_nxt = 4'h0;
					oe_nxt = 1'b1;
					st_nxt = srw_pkg::ST_ACK_WR;
				end
				srw_pkg::ST_RDATA: begin
					if (cnt_r == srw_pkg::BITS_PER_BYTE) begin
						oe_nxt = 1'b0;
						cnt_nxt = 4'h0;
						st_nxt = srw_pkg::ST_ACK_RD;
					end else begin
						tx_nxt = {tx_r[6:0], 1'b0};
						oe_nxt = !tx_r[6];
					end
				end
				srw_pkg::ST_ACK_RD: begin
					if (!hi_r) begin
						tx_nxt = rd_cur[7:0];
						hi_nxt = 1'b1;
					end else begin
						tx_nxt = rd_next[15:8];
						ptr_nxt = ptr_r + 8'h01;
						hi_nxt = 1'b0;
					end
					oe_nxt = !tx_nxt[7];
					st_nxt = srw_pkg::ST_RDATA;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= srw_pkg::ST_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			hold_r <= 8'h00;
			hi_r <= 1'b1;
			oe_r <= 1'b0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			hold_r <= hold_nxt;
			hi_r <= hi_nxt;
			oe_r <= oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// frame-synchronised apply and bad frame tracking
	// ----------------------------------------------------------------
	srw_cfg_if cfg ();
	logic apply, bad_m_r, bad_m_nxt, bad_r, bad_nxt;
	logic fs_o_nxt, fv_o_nxt, lv_o_nxt, hide;

	always_comb begin
		pend_nxt = pend_r;
		// register zero and unmapped offsets have a zero mask, so no store
		if (wr_en && srw_pkg::srw_field_mask(ptr_r) != 16'h0000)
			pend_nxt[ptr_r[2:0]] = wr_data & srw_pkg::srw_field_mask(ptr_r); // RL15
		apply = cfg.frame_start && !sync_changes_i; // RL2 RL16
		act_nxt = apply ? pend_r : act_r; // RL2
		dirty_nxt = apply ? 1'b0 : dirty_r;
		if (wr_en && srw_pkg::srw_field_mask(ptr_r) != 16'h0000)
			dirty_nxt = 1'b1;
		// every setting here is a masked-bad-frame one
		bad_m_nxt = cfg.frame_start ? (apply && dirty_r) : bad_m_r; // RL6
		bad_nxt = cfg.frame_start ? 1'b0 : bad_r;
		if (integ_change_i || offset_change_i)
			bad_nxt = 1'b1; // RL5
		hide = bad_m_r && !show_bad_frames_i; // RL6
		fs_o_nxt = cfg.frame_start;
		fv_o_nxt = cfg.fv && !hide;
		lv_o_nxt = cfg.lv && !hide;
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_r <= srw_pkg::RST_BANK;
			act_r <= srw_pkg::RST_BANK;
			dirty_r <= 1'b0;
			bad_m_r <= 1'b0;
			bad_r <= 1'b0;
			frame_start_o <= 1'b0;
			frame_valid_o <= 1'b0;
			line_valid_o <= 1'b0;
			row_addr_o <= 11'h000;
			col_addr_o <= 11'h000;
			bad_frame_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (ce_i) begin
			pend_r <= pend_nxt;
			act_r <= act_nxt;
			dirty_r <= dirty_nxt;
			bad_m_r <= bad_m_nxt;
			bad_r <= bad_nxt;
			frame_start_o <= fs_o_nxt;
			frame_valid_o <= fv_o_nxt;
			line_valid_o <= lv_o_nxt;
			row_addr_o <= cfg.row_addr;
			col_addr_o <= cfg.col_addr;
			bad_frame_o <= bad_r || bad_m_r;
			sda_o <= 1'b0;
			sda_oe_o <= oe_nxt;
		end
	end

	assign cfg.first_row = act_r[1][10:0]; // RL7
	assign cfg.first_col = act_r[2][10:0]; // RL9
	assign cfg.row_count = act_r[3][10:0]; // RL11
	assign cfg.col_count = act_r[4][10:0]; // RL12
	// context select is not frame synced and switches blanking at once
	assign cfg.hblank = context_select_i ? act_r[5][13:0] : srw_pkg::HBLANK_A; // RL1 RL13

	srw_readout_timing srw_readout_timing_i (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.cfg(cfg)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_addr_match;
		ce_i && fall && !start_ev && !stop_ev && st_r == srw_pkg::ST_DEV && cnt_r == 4'h8 && sh_r[7:1] == SLAVE_ADDR;
	endsequence
	sequence s_id_load;
		ce_i && fall && !start_ev && !stop_ev && st_r == srw_pkg::ST_ACK_DEV && sh_r[0] && ptr_r == 8'h00;
	endsequence

	a_addr_ack: assert property (s_addr_match |=> sda_oe_o && st_r == srw_pkg::ST_ACK_DEV)
		else $error("no acknowledge after matching address");
	a_id_value: assert property (s_id_load |=> tx_r == CHIP_ID[15:8] && sda_oe_o == !CHIP_ID[15]) // RL15
		else $error("identification high byte not loaded");
	a_id_no_write: assert property (ce_i && wr_en && ptr_r == 8'h00 |=> pend_r == $past(pend_r)) // RL15
		else $error("write to identification changed the bank");
	a_apply_start: assert property (ce_i && apply |=> act_r == $past(pend_r)) // RL2
		else $error("pending values not applied at frame start");
	a_hold_between: assert property (ce_i && !apply |=> act_r == $past(act_r)) // RL2
		else $error("applied values changed away from frame start");
	a_sync_hold: assert property (ce_i && cfg.frame_start && sync_changes_i && dirty_r |=> dirty_r) // RL16
		else $error("pending values dropped while sync bit set");
	a_mask_bad: assert property (ce_i && bad_m_r && !show_bad_frames_i |=> !frame_valid_o && !line_valid_o) // RL6
		else $error("masked bad frame was shown");
	a_mid_bad: assert property ((ce_i && (integ_change_i || offset_change_i)) ##1 (ce_i && !cfg.frame_start)
		|=> bad_frame_o) // RL5
		else $error("mid-frame change not flagged bad");
	a_ctx_blank: assert property (!context_select_i |-> cfg.hblank == srw_pkg::HBLANK_A) // RL13
		else $error("context B blanking used in context A");
endmodule

/* tb/srw_host_model.sv */
// two-wire serial host that drives the register port of the bank
`timescale 1ns/1ps
module srw_host_model (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// ----------------------------------------------------------------
	// bus idle: clock driven high, data released, pull-up gives high
	// ----------------------------------------------------------------
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// ----------------------------------------------------------------
	// bit level
	// ----------------------------------------------------------------
	task automatic gap();
		repeat (4) @(negedge clock_i);
	endtask

	// data moves mid low phase only, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		gap();
		sda_low_o = !b;
		gap();
		scl_o = 1'b1;
		gap();
		r = sda_i;
		gap();
		scl_o = 1'b0;
	endtask

	// also serves as repeated start
	task automatic start();
		gap();
		sda_low_o = 1'b0;
		gap();
		scl_o = 1'b1;
		gap();
		sda_low_o = 1'b1;
		gap();
		scl_o = 1'b0;
	endtask

	task automatic stop();
		gap();
		sda_low_o = 1'b1;
		gap();
		scl_o = 1'b1;
		gap();
		sda_low_o = 1'b0;
		gap();
	endtask

	// ----------------------------------------------------------------
	// byte level: send all ones to read; m is our ninth bit
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ack);
		logic r;
		q = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q = {q[6:0], r};
		end
		bit_io(m, r);
		ack = !r;
	endtask
endmodule

/* tb/test_sensor_readout_window_regs.sv */
// self-checking bench for the readout window register bank
`timescale 1ns/1ps
module test_sensor_readout_window_regs;
	localparam logic [6:0] DEV = 7'h21;
	localparam logic [15:0] ID = 16'h5A3C; // arbitrary identification value
	logic clock_i;
	logic arst_n_i = 1'b0;
	logic scl;
	logic host_low;
	logic sda_w;
	logic sda_o;
	logic sda_oe_o;
	logic ctx = 1'b0;
	logic integ = 1'b0;
	logic offs = 1'b0;
	logic fs;
	logic fv;
	logic lv;
	logic [10:0] ra;
	logic [10:0] ca;
	logic bad;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// open drain wire with pull-up
	assign sda_w = !(host_low || (sda_oe_o && !sda_o));

	srw_host_model srw_host_model_i (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));

	srw_readout_regs #(.SLAVE_ADDR(DEV), .CHIP_ID(ID)) srw_readout_regs_i (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .sync_changes_i(1'b0), .context_select_i(ctx),
		.show_bad_frames_i(1'b0), .integ_change_i(integ), .offset_change_i(offs),
		.frame_start_o(fs), .frame_valid_o(fv), .line_valid_o(lv), .row_addr_o(ra),
		.col_addr_o(ca), .bad_frame_o(bad));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic do_reset();
		arst_n_i = 1'b0;
		repeat (2) @(negedge clock_i);
		arst_n_i = 1'b1;
		repeat (4) @(negedge clock_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [6:0] dev);
		logic [7:0] q;
		logic k;
		logic all;
		srw_host_model_i.start();
		srw_host_model_i.xfer({dev, 1'b0}, 1'b1, q, all);
		srw_host_model_i.xfer(a, 1'b1, q, k);
		all &= k;
		srw_host_model_i.xfer(v[15:8], 1'b1, q, k);
		all &= k;
		srw_host_model_i.xfer(v[7:0], 1'b1, q, k);
		all &= k;
		srw_host_model_i.stop();
		check(all, dev == DEV, "write acks");
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		logic [7:0] q;
		logic k;
		srw_host_model_i.start();
		srw_host_model_i.xfer({DEV, 1'b0}, 1'b1, q, k);
		srw_host_model_i.xfer(a, 1'b1, q, k);
		srw_host_model_i.start();
		srw_host_model_i.xfer({DEV, 1'b1}, 1'b1, q, k);
		srw_host_model_i.xfer(8'hFF, 1'b0, v[15:8], k);
		srw_host_model_i.xfer(8'hFF, 1'b1, v[7:0], k);
		srw_host_model_i.stop();
	endtask

	task automatic span(input logic lvl, output int n);
		n = 0;
		while (lv === lvl && n < 5000) begin
			@(negedge clock_i);
			n++;
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset_values();
		logic [15:0] exp [0:6];
		logic [15:0] v;
		exp = '{ID, 16'h001C, 16'h003C, 16'h04B0, 16'h0640, 16'h015C, 16'h0000};
		for (int i = 0; i < 7; i++) begin
			rd(i[7:0], v);
			check(v, exp[i], "reset value");
		end
		$display("done reset values");
	endtask

	task automatic test_writes();
		logic [15:0] v;
		wr(8'h00, 16'h1234, DEV);
		rd(8'h00, v);
		check(v, ID, "id after write");
		wr(8'h05, 16'hFFFF, DEV);
		rd(8'h05, v);
		check(v, 16'h3FFF, "blanking width");
		wr(8'h01, 16'hF830, DEV);
		rd(8'h01, v);
		check(v, 16'h0030, "first row width");
		wr(8'h02, 16'h0040, 7'h22);
		rd(8'h02, v);
		check(v, 16'h003C, "foreign address");
		wr(8'h02, 16'h0034, DEV);
		wr(8'h04, 16'h0011, DEV);
		rd(8'h02, v);
		check(v, 16'h0034, "first column pending");
		$display("done writes");
	endtask

	// pending window values must not reach the readout mid frame
	task automatic test_pending_and_lines();
		int n;
		n = 0;
		while (lv !== 1'b1 && n < 30000) begin
			@(negedge clock_i);
			n++;
		end
		check(lv, 1'b1, "line start");
		check(fv, 1'b1, "frame active on line");
		check(ra, 11'h01C, "row address");
		check(ca, 11'h03C, "column address");
		span(1'b1, n);
		check(n, 16'h0640, "active columns");
		span(1'b0, n);
		check(n, 16'h00AE, "blank context a");
		// switching mid line blanks the current row again up to column 15C, so judge its remaining active run
		ctx = 1'b1;
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, n);
		check(n[15:0], 16'h0640, "active columns b");
		span(1'b0, n);
		check(n[15:0], 16'h015C, "blank context b");
		ctx = 1'b0;
		$display("done readout");
	endtask

	task automatic test_bad(input logic use_offset);
		check(bad, 1'b0, "bad before event");
		integ = !use_offset;
		offs = use_offset;
		@(negedge clock_i);
		integ = 1'b0;
		offs = 1'b0;
		repeat (2) @(negedge clock_i);
		check(bad, 1'b1, "bad after event");
		$display("done bad frame");
	endtask

	// after reset the counters sit at the first dark row, eight lines before frame active
	task automatic test_fv_lead();
		int n;
		arst_n_i = 1'b0;
		repeat (2) @(negedge clock_i);
		arst_n_i = 1'b1;
		n = 0;
		while (fv !== 1'b1 && n < 20000) begin
			@(negedge clock_i);
			n++;
		end
		// eight lines of context A blanking plus columns, one more for the output flop
		check(n[15:0], 16'h3771, "frame active lead");
		check(fs, 1'b0, "no start in first frame");
		$display("done frame lead");
	endtask

	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			finish_test();
		end
	end

	initial begin
		do_reset();
		test_reset_values();
		test_writes();
		test_pending_and_lines();
		test_bad(1'b0);
		do_reset();
		test_bad(1'b1);
		test_fv_lead();
		finish_test();
	end
endmodule
